// ---- logic/interrupt_enable_priority_bits.sv ----
// interrupt source enable and priority select registers with request gating
// Behaviour
// R1 - async serial enable masks serial port requests when clear, passes them when set
// R2 - timer one enable blocks timer one requests when clear, passes overflow flag when set
// R3 - timer zero enable blocks timer zero requests when clear, passes overflow flag when set
// R4 - serial peripheral priority bit: clear gives low, set gives high priority
// R5 - async serial priority bit selects async serial interrupt priority level
// R6 - async serial priority set means high, clear means low
// R7 - external line enables each gate their own external input requests
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
module interrupt_enable_priority_bits (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  // interrupt sources, index by bit position; bit 7 unused
  input wire logic async_serial_request,
  input wire logic timer_one_overflow_flag,
  input wire logic ext_line_one_input,
  input wire logic timer_zero_overflow_flag,
  input wire logic ext_line_zero_input,
  input wire logic timer_two_request,
  input wire logic serial_periph_request,
  // gated requests toward the core, one bit per source
  output logic [6:0] high_requests,
  output logic [6:0] low_requests
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic reset_meta;
  logic reset_sync_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_meta <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta <= 1'b1;
      reset_sync_n <= reset_meta;
    end
  end
  // ----------------------------------------------------------------
  // external lines: pins, synchronised; active low on the pin
  // ----------------------------------------------------------------
  logic [1:0] ext_meta;
  logic [1:0] ext_sync;
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      ext_meta <= 2'h3;
      ext_sync <= 2'h3;
    end else begin
      ext_meta <= {ext_line_one_input, ext_line_zero_input};
      ext_sync <= ext_meta;
    end
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] interrupt_source_enable;
  logic [7:0] interrupt_priority_select;
  logic [7:0] next_source_enable;
  logic [7:0] next_priority_select;
  logic [7:0] next_read_data;
  always_comb begin
    next_source_enable = interrupt_source_enable;
    next_priority_select = interrupt_priority_select;
    next_read_data = 8'h00;
    if (write_strobe && address == irq_bits_pkg::source_enable_addr) begin
      next_source_enable = write_data;
    end
    if (write_strobe && address == irq_bits_pkg::priority_select_addr) begin
      // top bit is fixed; writes there are ignored
      next_priority_select = write_data | irq_bits_pkg::priority_read_ones;
    end
    if (read_strobe) begin
      case (address)
        irq_bits_pkg::source_enable_addr: next_read_data = interrupt_source_enable;
        irq_bits_pkg::priority_select_addr: next_read_data = interrupt_priority_select;
        default: next_read_data = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      interrupt_source_enable <= irq_bits_pkg::source_enable_reset;
      interrupt_priority_select <= irq_bits_pkg::priority_select_reset;
      read_data <= 8'h00;
    end else begin
      interrupt_source_enable <= next_source_enable;
      interrupt_priority_select <= next_priority_select;
      read_data <= next_read_data;
    end
  end
  // ----------------------------------------------------------------
  // gating: bit n of each register controls source n
  // ----------------------------------------------------------------
  logic [6:0] raw_requests;
  always_comb begin
    raw_requests[irq_bits_pkg::ext_zero_bit] = ~ext_sync[0]; // R7
    raw_requests[irq_bits_pkg::timer_zero_bit] = timer_zero_overflow_flag; // R3
    raw_requests[irq_bits_pkg::ext_one_bit] = ~ext_sync[1]; // R7
    raw_requests[irq_bits_pkg::timer_one_bit] = timer_one_overflow_flag; // R2
    raw_requests[irq_bits_pkg::async_serial_bit] = async_serial_request; // R1
    raw_requests[irq_bits_pkg::timer_two_bit] = timer_two_request;
    raw_requests[irq_bits_pkg::serial_periph_bit] = serial_periph_request; // R4
  end
  // enable and priority share bit positions, so one gate per position
  genvar gi;
  generate
    for (gi = 0; gi < irq_bits_pkg::source_count; gi++) begin : gate_loop
      irq_gate gate (
        .request(raw_requests[gi]),
        .enable(interrupt_source_enable[gi]),
        .high_priority(interrupt_priority_select[gi]), // R5 R6
        .high_request(high_requests[gi]),
        .low_request(low_requests[gi])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int as_bit = irq_bits_pkg::async_serial_bit;
  localparam int t1_bit = irq_bits_pkg::timer_one_bit;
  localparam int t0_bit = irq_bits_pkg::timer_zero_bit;
  localparam int sp_bit = irq_bits_pkg::serial_periph_bit;
  localparam int x1_bit = irq_bits_pkg::ext_one_bit;
  localparam int x0_bit = irq_bits_pkg::ext_zero_bit;
  property p_async_serial_gate; // R1
    @(posedge clk) disable iff (!reset_sync_n)
      (high_requests[as_bit] | low_requests[as_bit]) == (async_serial_request & interrupt_source_enable[as_bit]);
  endproperty
  a_async_serial_gate: assert property (p_async_serial_gate) else $error("async serial gate wrong"); // R1
  property p_timer_one_gate; // R2
    @(posedge clk) disable iff (!reset_sync_n)
      (high_requests[t1_bit] | low_requests[t1_bit]) == (timer_one_overflow_flag & interrupt_source_enable[t1_bit]);
  endproperty
  a_timer_one_gate: assert property (p_timer_one_gate) else $error("timer one gate wrong"); // R2
  property p_timer_zero_gate; // R3
    @(posedge clk) disable iff (!reset_sync_n)
      (high_requests[t0_bit] | low_requests[t0_bit]) == (timer_zero_overflow_flag & interrupt_source_enable[t0_bit]);
  endproperty
  a_timer_zero_gate: assert property (p_timer_zero_gate) else $error("timer zero gate wrong"); // R3
  property p_serial_periph_level; // R4
    @(posedge clk) disable iff (!reset_sync_n)
      (serial_periph_request && interrupt_source_enable[sp_bit])
        |-> (high_requests[sp_bit] == interrupt_priority_select[sp_bit]);
  endproperty
  a_serial_periph_level: assert property (p_serial_periph_level) else $error("serial periph level wrong"); // R4
  property p_async_priority_write; // R5
    @(posedge clk) disable iff (!reset_sync_n)
      (write_strobe && address == irq_bits_pkg::priority_select_addr)
        |=> interrupt_priority_select[as_bit] == $past(write_data[as_bit]);
  endproperty
  a_async_priority_write: assert property (p_async_priority_write) else $error("priority write lost"); // R5
  property p_async_level; // R6
    @(posedge clk) disable iff (!reset_sync_n)
      (async_serial_request && interrupt_source_enable[as_bit] && !interrupt_priority_select[as_bit])
        |-> (low_requests[as_bit] && !high_requests[as_bit]);
  endproperty
  a_async_level: assert property (p_async_level) else $error("async level wrong"); // R6
  property p_ext_one_blocked; // R7
    @(posedge clk) disable iff (!reset_sync_n)
      !interrupt_source_enable[x1_bit] |-> !(high_requests[x1_bit] | low_requests[x1_bit]);
  endproperty
  a_ext_one_blocked: assert property (p_ext_one_blocked) else $error("ext one not blocked"); // R7
  property p_ext_zero_pass; // R7
    @(posedge clk) disable iff (!reset_sync_n)
      (!ext_line_zero_input && interrupt_source_enable[x0_bit])[*3]
        |-> (high_requests[x0_bit] | low_requests[x0_bit]);
  endproperty
  a_ext_zero_pass: assert property (p_ext_zero_pass) else $error("ext zero not passed"); // R7
  property p_top_reads_one;
    @(posedge clk) disable iff (!reset_sync_n)
      (read_strobe && address == irq_bits_pkg::priority_select_addr) |=> read_data[7];
  endproperty
  a_top_reads_one: assert property (p_top_reads_one) else $error("top bit read as zero");
  property p_async_high; // R6
    @(posedge clk) disable iff (!reset_sync_n)
      (async_serial_request && interrupt_source_enable[as_bit] && interrupt_priority_select[as_bit])
        |-> (high_requests[as_bit] && !low_requests[as_bit]);
  endproperty
  a_async_high: assert property (p_async_high) else $error("async high level wrong"); // R6
  property p_ext_one_pass; // R7
    @(posedge clk) disable iff (!reset_sync_n)
      (!ext_line_one_input && interrupt_source_enable[x1_bit])[*3]
        |-> (high_requests[x1_bit] | low_requests[x1_bit]);
  endproperty
  a_ext_one_pass: assert property (p_ext_one_pass) else $error("ext one not passed"); // R7
  property p_ext_zero_blocked; // R7
    @(posedge clk) disable iff (!reset_sync_n)
      !interrupt_source_enable[x0_bit] |-> !(high_requests[x0_bit] | low_requests[x0_bit]);
  endproperty
  a_ext_zero_blocked: assert property (p_ext_zero_blocked) else $error("ext zero not blocked"); // R7
  property p_enable_write; // R1
    @(posedge clk) disable iff (!reset_sync_n)
      (write_strobe && address == irq_bits_pkg::source_enable_addr)
        |=> interrupt_source_enable == $past(write_data);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // R1
  property p_priority_top_fixed;
    @(posedge clk) disable iff (!reset_sync_n)
      interrupt_priority_select[irq_bits_pkg::top_bit];
  endproperty
  a_priority_top_fixed: assert property (p_priority_top_fixed) else $error("top priority bit cleared");
  property p_read_idle_zero;
    @(posedge clk) disable iff (!reset_sync_n)
      !read_strobe |=> (read_data == 8'h00);
  endproperty
  a_read_idle_zero: assert property (p_read_idle_zero) else $error("read data not zero when idle");
  property p_unmapped_write_ignored;
    @(posedge clk) disable iff (!reset_sync_n)
      (write_strobe && address != irq_bits_pkg::source_enable_addr
        && address != irq_bits_pkg::priority_select_addr)
        |=> ($stable(interrupt_source_enable) && $stable(interrupt_priority_select));
  endproperty
  a_unmapped_write_ignored: assert property (p_unmapped_write_ignored) else $error("unmapped write landed");
  c_async_high: cover property (@(posedge clk) disable iff (!reset_sync_n) high_requests[as_bit]);
  c_timer_one_low: cover property (@(posedge clk) disable iff (!reset_sync_n) low_requests[t1_bit]);
  c_ext_one_high: cover property (@(posedge clk) disable iff (!reset_sync_n) high_requests[x1_bit]);
  // only the high level of the serial sources is covered, for the async one and the peripheral one alike
  c_ext_zero_low: cover property (@(posedge clk) disable iff (!reset_sync_n) low_requests[x0_bit]);
  c_serial_periph_high: cover property (@(posedge clk) disable iff (!reset_sync_n) high_requests[sp_bit]);
endmodule

// ---- logic/irq_bits_pkg.sv ----
// constants for the interrupt enable and priority register bits
package irq_bits_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] source_enable_addr = 8'ha8;
  localparam logic [7:0] priority_select_addr = 8'hb8;
  // ----------------------------------------------------------------
  // field positions, shared by both registers
  // ----------------------------------------------------------------
  localparam int ext_zero_bit = 0;
  localparam int timer_zero_bit = 1;
  localparam int ext_one_bit = 2;
  localparam int timer_one_bit = 3;
  localparam int async_serial_bit = 4;
  localparam int timer_two_bit = 5;
  localparam int serial_periph_bit = 6;
  localparam int top_bit = 7;
  localparam int source_count = 7;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] source_enable_reset = 8'h00;
  localparam logic [7:0] priority_select_reset = 8'h80;
  // unused top priority bit reads as one
  localparam logic [7:0] priority_read_ones = 8'h80;
endpackage

// ---- logic/irq_gate.sv ----
// one source: enable gate and priority split
`timescale 1ns/10ps
module irq_gate (
  // request and controls
  input wire logic request,
  input wire logic enable,
  input wire logic high_priority,
  // gated request per level
  output logic high_request,
  output logic low_request
);
  always_comb begin
    high_request = request & enable & high_priority;
    low_request = request & enable & ~high_priority;
  end
endmodule

// ---- testbench/core_bus_model.sv ----
// processor core model driving the register port
`timescale 1ns/10ps
module core_bus_model (
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] address,
  output logic [7:0] write_data,
  output logic write_strobe,
  output logic read_strobe,
  input wire logic [7:0] read_data
);
  initial begin
    address = 8'h00;
    write_data = 8'h00;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
  end
  // one-cycle write, strobe dropped at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the enable and priority register bits
`timescale 1ns/10ps
module testbench;
  logic clk;
  logic reset_n;
  logic [7:0] address, write_data, read_data, d, e, p, r, en, pri, eh, el;
  logic write_strobe, read_strobe;
  logic [6:0] high_requests, low_requests;
  logic [7:0] req;
  integer seed = 32'h01a6;
  int n_fail = 0;
  int tests_run = 0;
  // ----------------------------------------------------------------
  // clock, partner and design
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  core_bus_model core (.clk(clk), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data));
  interrupt_enable_priority_bits dut (.clk(clk), .reset_n(reset_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .async_serial_request(req[4]), .timer_one_overflow_flag(req[3]), .ext_line_one_input(~req[2]),
    .timer_zero_overflow_flag(req[1]), .ext_line_zero_input(~req[0]), .timer_two_request(req[5]),
    .serial_periph_request(req[6]), .high_requests(high_requests), .low_requests(low_requests));
  // ----------------------------------------------------------------
  // checking and verdict
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // gated outputs from the model, external lines already two cycles settled
  task automatic check_outputs();
    for (int j = 0; j < 7; j++) begin
      eh[j] = r[j] & en[j] & pri[j];
      el[j] = r[j] & en[j] & ~pri[j];
    end
    eh[7] = 1'b0;
    el[7] = 1'b0;
    #1;
    check("high_requests", {1'b0, high_requests}, eh);
    check("low_requests", {1'b0, low_requests}, el);
  endtask
  initial begin
    #(20 * 20000);
    n_fail++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    req = 8'h00;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    en = irq_bits_pkg::source_enable_reset;
    pri = irq_bits_pkg::priority_select_reset;
    r = 8'h00;
    core.rd(irq_bits_pkg::source_enable_addr, d);
    check("enable_reset", d, en);
    core.rd(irq_bits_pkg::priority_select_addr, d);
    check("priority_reset", d, pri);
    for (int i = 0; i < 30; i++) begin
      e = 8'($random(seed));
      p = 8'($random(seed));
      r = 8'($random(seed));
      if (i == 0) begin
        e = 8'hff;
        p = 8'h00;
        r = 8'hff;
      end
      if (i == 1) begin
        e = 8'hff;
        p = 8'h7f;
        r = 8'hff;
      end
      core.wr(irq_bits_pkg::source_enable_addr, e);
      core.wr(irq_bits_pkg::priority_select_addr, p);
      core.wr(8'h5a, ~e);
      en = e;
      pri = p | irq_bits_pkg::priority_read_ones;
      req <= r;
      repeat (3) @(posedge clk);
      check_outputs();
      core.rd(irq_bits_pkg::source_enable_addr, d);
      check("enable_read", d, en);
      core.rd(irq_bits_pkg::priority_select_addr, d);
      check("priority_read", d, pri);
      core.rd(8'h5a, d);
      check("unmapped_read", d, 8'h00);
    end
    give_verdict();
  end
endmodule
